// >>> include/strap_pkg.sv
// Constants, register map and field layout of the strap capture block
// Behaviour
// - Register 0 holds strap lines 7..0
// - Register 1 holds strap lines 15..8
// - Registers 0 and 1 load at reset
// - Memory straps are read-back only
// - Type 0 EDO, speed 0 70ns
// - Register 2 holds lines 20..16, 23
// - Only register 2 bit 4 writable
// - Register 2 bit 1 picks PCI divisor
// - Register 2 loads at reset
// - Host clock register holds lines 26..21
// - Bits 5..3 select host clock frequency
// - Host clock register loads at reset
// - Line 40 sets core multiplier x1/x2
// - Line 0 picks ISA or colour compare
// - Line 0 low colour compare, high ISA
package strap_pkg;

	// ****************************************************************
	// Strap lines and register map
	// ****************************************************************
	localparam int unsigned STRAP_LINES = 44;
	localparam int unsigned ADR_W       = 10;
	localparam logic [7:0] IDX_SIMM_LOW  = 8'h4a;
	localparam logic [7:0] IDX_SIMM_HIGH = 8'h4b;
	localparam logic [7:0] IDX_PCI_DIV   = 8'h4c;
	localparam logic [7:0] IDX_HCLK_SEL  = 8'h5f;

	// ****************************************************************
	// Strap line positions
	// ****************************************************************
	localparam int unsigned LINE_SIMM_LOW  = 0;
	localparam int unsigned LINE_SIMM_HIGH = 8;
	localparam int unsigned LINE_PCI_LOW   = 16;
	localparam int unsigned LINE_PCI_TOP   = 23;
	localparam int unsigned LINE_HCLK      = 21;
	localparam int unsigned LINE_CORE      = 40;
	localparam int unsigned LINE_FUNC      = 0;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int unsigned SIMM_A_TYPE_BIT = 7;
	localparam int unsigned SIMM_A_SPD_LSB  = 5;
	localparam int unsigned SIMM_B_TYPE_BIT = 4;
	localparam int unsigned SIMM_B_SPD_LSB  = 2;
	localparam int unsigned PCI_DIV3_BIT    = 1;
	localparam int unsigned PCI_WR_BIT      = 4;
	localparam int unsigned HCLK_SEL_LSB    = 3;

	// ****************************************************************
	// Encodings and reset values
	// ****************************************************************
	localparam logic TYPE_EDO   = 1'b0;
	localparam logic TYPE_FPM   = 1'b1;
	localparam logic SPEED_70NS = 1'b0;
	localparam logic SPEED_60NS = 1'b1;
	localparam logic FUNC_COLOUR_COMPARE = 1'b0;
	localparam logic FUNC_ISA_WRITE      = 1'b1;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] DIV2_LAST  = 2'h1;
	localparam logic [1:0] DIV3_LAST  = 2'h2;

	// Host clock frequency in MHz for each select code
	localparam logic [6:0] HCLK_MHZ [8] = '{
		7'h19, 7'h21, 7'h28, 7'h32, 7'h3c, 7'h42, 7'h4b, 7'h50
	};

endpackage

// >>> logic/strap_option_capture.sv
// Strap capture, read-back registers and strap-driven controls
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module strap_option_capture (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Board strap levels on the memory data lines
	input  wire logic [43:0] strap_data_lines,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Strap-driven controls
	output logic             pci_clock_out,
	output logic      [2:0]  host_clock_select,
	output logic      [6:0]  host_clock_mhz,
	output logic             double_speed_core,
	output logic             isa_memory_write_select,
	output logic             straps_valid
);

	// ****************************************************************
	// Capture state
	// ****************************************************************
	logic       capture_pending_reg;
	logic [7:0] simm_low_pair_strap_reg;
	logic [7:0] simm_high_pair_strap_reg;
	logic [5:0] pci_divisor_strap_reg;
	logic [5:0] pci_divisor_strap_next;
	logic [5:0] host_clock_select_strap_reg;
	logic       core_x2_reg;
	logic       func_isa_reg;

	// Strap levels mapped into register layout
	logic [7:0] cap_simm_low;
	logic [7:0] cap_simm_high;
	logic [5:0] cap_pci_div;
	logic [5:0] cap_hclk;

	// Type and speed levels pass unchanged
	assign cap_simm_low  = strap_data_lines[strap_pkg::LINE_SIMM_LOW +: 8];
	assign cap_simm_high = strap_data_lines[strap_pkg::LINE_SIMM_HIGH +: 8];
	assign cap_pci_div   = {strap_data_lines[strap_pkg::LINE_PCI_TOP],
		strap_data_lines[strap_pkg::LINE_PCI_LOW +: 5]};
	// Lines 26..21 into host clock register
	assign cap_hclk      = strap_data_lines[strap_pkg::LINE_HCLK +: 6];

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic [7:0]  bus_index;
	logic        bus_req;
	logic        wr_fire;
	logic        hit_simm_low;
	logic        hit_simm_high;
	logic        hit_pci_div;
	logic        hit_hclk;
	logic [7:0]  read_byte;
	logic [31:0] read_word;

	assign bus_index     = wb_adr_i[9:2];
	assign bus_req       = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack
	assign wr_fire       = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign hit_simm_low  = bus_index == strap_pkg::IDX_SIMM_LOW;
	assign hit_simm_high = bus_index == strap_pkg::IDX_SIMM_HIGH;
	assign hit_pci_div   = bus_index == strap_pkg::IDX_PCI_DIV;
	assign hit_hclk      = bus_index == strap_pkg::IDX_HCLK_SEL;

	// Unmapped indexes read as zero
	assign read_byte =
		hit_simm_low  ? simm_low_pair_strap_reg :
		hit_simm_high ? simm_high_pair_strap_reg :
		hit_pci_div   ? {2'h0, pci_divisor_strap_reg} :
		hit_hclk      ? {2'h0, host_clock_select_strap_reg} :
		strap_pkg::RESET_BYTE;
	assign read_word = {24'h000000, read_byte};

	// Only bit 4 of register 2 takes a write
	always_comb begin
		pci_divisor_strap_next = pci_divisor_strap_reg;
		if (wr_fire && hit_pci_div) begin
			pci_divisor_strap_next[strap_pkg::PCI_WR_BIT] =
				wb_dat_i[strap_pkg::PCI_WR_BIT];
		end
	end

	// ****************************************************************
	// Strap capture
	// ****************************************************************
	// The first edge after reset release samples the pins, so the
	// board must keep the straps stable through that edge.
	// Capture once, hold afterwards
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			capture_pending_reg <= 1'b1;
		end else begin
			capture_pending_reg <= 1'b0;
		end
	end

	// Register 0 and 1 load from the pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			simm_low_pair_strap_reg  <= strap_pkg::RESET_BYTE;
			simm_high_pair_strap_reg <= strap_pkg::RESET_BYTE;
		end else if (capture_pending_reg) begin
			simm_low_pair_strap_reg  <= cap_simm_low;
			simm_high_pair_strap_reg <= cap_simm_high;
		end
	end

	// Register 2 loads from the pins, then software bit 4
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pci_divisor_strap_reg <= 6'h00;
		end else if (capture_pending_reg) begin
			pci_divisor_strap_reg <= cap_pci_div;
		end else begin
			pci_divisor_strap_reg <= pci_divisor_strap_next;
		end
	end

	// Host clock register loads from the pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			host_clock_select_strap_reg <= 6'h00;
		end else if (capture_pending_reg) begin
			host_clock_select_strap_reg <= cap_hclk;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			core_x2_reg  <= 1'b0;
			func_isa_reg <= strap_pkg::FUNC_COLOUR_COMPARE;
		end else if (capture_pending_reg) begin
			core_x2_reg  <= strap_data_lines[strap_pkg::LINE_CORE];
			func_isa_reg <= strap_data_lines[strap_pkg::LINE_FUNC];
		end
	end

	// Memory type and speed fields drive no control logic
	// software alone reads them back.

	// ****************************************************************
	// PCI clock divider
	// ****************************************************************
	logic [1:0] div_cnt_reg;
	logic [1:0] div_cnt_next;
	logic [1:0] div_last;

	// Bit 1 low divides by two, high by three
	assign div_last = pci_divisor_strap_reg[strap_pkg::PCI_DIV3_BIT]
		? strap_pkg::DIV3_LAST : strap_pkg::DIV2_LAST;
	// Wrap at or above the limit so a change of divisor never hangs
	assign div_cnt_next = (div_cnt_reg >= div_last) ? 2'h0
		: div_cnt_reg + 2'h1;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_reg   <= 2'h0;
			pci_clock_out <= 1'b0;
		end else if (capture_pending_reg) begin
			div_cnt_reg   <= 2'h0;
			pci_clock_out <= 1'b0;
		end else begin
			div_cnt_reg   <= div_cnt_next;
			pci_clock_out <= div_cnt_next == 2'h0;
		end
	end

	// ****************************************************************
	// Control outputs
	// ****************************************************************
	logic [2:0] hclk_code;

	// Bits 5..3 steer the synthesizer select
	assign hclk_code = host_clock_select_strap_reg[strap_pkg::HCLK_SEL_LSB +: 3];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			host_clock_select       <= 3'h0;
			host_clock_mhz          <= 7'h00;
			double_speed_core       <= 1'b0;
			isa_memory_write_select <= 1'b0;
			straps_valid            <= 1'b0;
		end else begin
			host_clock_select       <= hclk_code;
			host_clock_mhz          <= strap_pkg::HCLK_MHZ[hclk_code];
			double_speed_core       <= core_x2_reg;
			// High picks ISA write, low colour compare
			isa_memory_write_select <= func_isa_reg == strap_pkg::FUNC_ISA_WRITE;
			straps_valid            <= ~capture_pending_reg;
		end
	end

	// ****************************************************************
	// Bus answer
	// ****************************************************************
	// One wait cycle: ack and data rise together, then ack drops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			if (bus_req && !wb_ack_o) begin
				wb_dat_o <= wb_we_i ? 32'h00000000 : read_word;
			end
		end
	end

endmodule

// >>> verif/strap_board.sv
// Board strap resistors: user straps plus fixed pulls on reserved lines
`timescale 1ns/1ps
module strap_board (
	// User-chosen strap levels
	input  wire logic [43:0] user_levels,
	// Levels seen on the memory data lines at reset
	output logic      [43:0] strap_data_lines
);
	// User-defined lines other than line 8 follow the setting; line 8 is also pulled up, and reserved lines sit on their pulls
	localparam logic [43:0] USER_MASK = 44'h1000702b5b5;
	localparam logic [43:0] PULL_UP   = 44'h4f000fd4948;
	// Line 0 is a user strap
	assign strap_data_lines = (user_levels & USER_MASK) | PULL_UP;
endmodule

// >>> verif/strap_option_capture_props.sv
// Port-level checker for the strap capture block
`timescale 1ns/1ps
module strap_option_capture_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Straps and bus
	input wire logic [43:0] strap_data_lines,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [9:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Controls
	input wire logic        pci_clock_out,
	input wire logic [2:0]  host_clock_select,
	input wire logic [6:0]  host_clock_mhz,
	input wire logic        double_speed_core,
	input wire logic        isa_memory_write_select,
	input wire logic        straps_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	wire mapped = wb_adr_i[9:2] inside {strap_pkg::IDX_SIMM_LOW, strap_pkg::IDX_SIMM_HIGH, strap_pkg::IDX_PCI_DIV,
		strap_pkg::IDX_HCLK_SEL};
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
	unmapped_zero_a: assert property (wb_ack_o && !mapped |-> wb_dat_o == 32'h0) else $error("unmapped data");
	mhz_map_a: assert property (straps_valid |-> host_clock_mhz == strap_pkg::HCLK_MHZ[host_clock_select])
		else $error("frequency mismatch");
	sel_stable_a: assert property (straps_valid |=> $stable(host_clock_select) && $stable(double_speed_core)
		&& $stable(isa_memory_write_select) && straps_valid) else $error("controls moved");
	pci_high_a: assert property (pci_clock_out |=> !pci_clock_out) else $error("pci high too long");
	pci_low_a: assert property ($past(straps_valid, 4) && !pci_clock_out |-> ##[1:2] pci_clock_out)
		else $error("pci low too long");
	// Pins are sampled on the first edge after release; controls show them one edge later
	capture_match_a: assert property ($rose(straps_valid) |->
		double_speed_core == $past(strap_data_lines[strap_pkg::LINE_CORE], 2)
		&& isa_memory_write_select == $past(strap_data_lines[strap_pkg::LINE_FUNC], 2)
		&& host_clock_select == $past(strap_data_lines[strap_pkg::LINE_HCLK + strap_pkg::HCLK_SEL_LSB +: 3], 2))
		else $error("controls differ from captured straps");
	cover property (wb_ack_o && wb_we_i);
	cover property (wb_ack_o && !wb_we_i && mapped);
	cover property (straps_valid && double_speed_core);
	cover property ($rose(straps_valid) && isa_memory_write_select);
endmodule
bind strap_option_capture strap_option_capture_props u_props (.clk(clk), .resetn(resetn),
	.strap_data_lines(strap_data_lines), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pci_clock_out(pci_clock_out), .host_clock_select(host_clock_select), .host_clock_mhz(host_clock_mhz),
	.double_speed_core(double_speed_core), .isa_memory_write_select(isa_memory_write_select),
	.straps_valid(straps_valid));

// >>> verif/strap_option_capture_tb.sv
// Self-checking bench for the strap capture block
`timescale 1ns/1ps
module strap_option_capture_tb;
	logic        clk = 0, resetn = 0, req = 0, wen = 0;
	logic [9:0]  adr = 10'h0;
	logic [3:0]  sel = 4'h1;
	logic [31:0] wdat = 32'h0;
	logic [43:0] user = 44'h0, cap;
	wire  [43:0] sl;
	wire  [31:0] rdat;
	wire         ack, pci, valid, dbl, isa;
	wire  [2:0]  hsel;
	wire  [6:0]  mhz;
	int          mismatches = 0, tests_run = 0;
	int          mhz_t [8] = '{25, 33, 40, 50, 60, 66, 75, 80};
	always #5 clk = ~clk;
	strap_board BOARD (.user_levels(user), .strap_data_lines(sl));
	strap_option_capture DUT (.clk(clk), .resetn(resetn), .strap_data_lines(sl), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.pci_clock_out(pci), .host_clock_select(hsel), .host_clock_mhz(mhz), .double_speed_core(dbl),
		.isa_memory_write_select(isa), .straps_valid(valid));
	task automatic summarize;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask
	// One classic cycle; waits for ack, then one idle cycle
	task automatic bus(input logic [7:0] idx, input logic we, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		adr <= {idx, 2'b00};
		wen <= we;
		wdat <= {24'h0, wd};
		req <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			$display("wrong value at %0t: bus timeout", $time);
			summarize();
		end
		rd = rdat[7:0];
		req <= 1'b0;
		@(posedge clk);
	endtask
	task automatic boot(input logic [43:0] u);
		resetn <= 1'b0;
		user <= u;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		cap = sl;
	endtask
	task automatic sweep_codes;
		logic [43:0] u;
		int          hi;
		for (int i = 0; i < 8; i++) begin
			u = 44'h0;
			u[26:24] = i[2:0];
			u[17] = i[0];
			u[40] = i[1];
			u[0] = i[2];
			boot(u);
			cmp(hsel, i, "code");
			cmp(mhz, mhz_t[i], "mhz");
			cmp(dbl, i[1], "core");
			cmp(isa, i[2], "func");
			cmp(valid, 1, "valid");
			hi = 0;
			repeat (6) begin
				@(posedge clk);
				if (pci === 1'b1)
					hi++;
			end
			cmp(hi, i[0] ? 2 : 3, "pci highs");
		end
	endtask
	task automatic read_regs;
		logic [7:0] r;
		boot(44'h1c5_0a5_3ca5);
		bus(8'h4a, 1'b0, 8'h0, r);
		cmp(r, cap[7:0], "reg 4a");
		bus(8'h4b, 1'b0, 8'h0, r);
		cmp(r, cap[15:8], "reg 4b");
		bus(8'h4c, 1'b0, 8'h0, r);
		cmp(r, {2'b0, cap[23], cap[20:16]}, "reg 4c");
		bus(8'h5f, 1'b0, 8'h0, r);
		cmp(r, {2'b0, cap[26:21]}, "reg 5f");
		bus(8'h10, 1'b0, 8'h0, r);
		cmp(r, 0, "unmapped");
	endtask
	task automatic write_regs;
		logic [7:0] r, e;
		e = {2'b0, cap[23], cap[20:16]};
		bus(8'h4c, 1'b1, ~e, r);
		bus(8'h4c, 1'b0, 8'h0, r);
		cmp(r, e ^ 8'h10, "write 4c");
		// Without byte lane 0 the writable bit must keep its value
		sel <= 4'h0;
		bus(8'h4c, 1'b1, e, r);
		sel <= 4'h1;
		bus(8'h4c, 1'b0, 8'h0, r);
		cmp(r, e ^ 8'h10, "masked 4c");
		bus(8'h4a, 1'b1, ~cap[7:0], r);
		bus(8'h4a, 1'b0, 8'h0, r);
		cmp(r, cap[7:0], "write 4a");
	endtask
	task automatic late_change;
		logic [7:0] r;
		user <= ~user;
		repeat (2) @(posedge clk);
		bus(8'h5f, 1'b0, 8'h0, r);
		cmp(r, {2'b0, cap[26:21]}, "late 5f");
		bus(8'h4b, 1'b0, 8'h0, r);
		cmp(r, cap[15:8], "late 4b");
		cmp(hsel, cap[26:24], "late code");
		cmp(dbl, cap[40], "late core");
		cmp(isa, cap[0], "late func");
	endtask
	initial begin
		@(posedge clk);
		sweep_codes();
		read_regs();
		write_regs();
		late_change();
		summarize();
	end
endmodule
